//--- hdl/sltc_pkg.sv
package sltc_pkg;
  // Lane vector over three ports, one byte per port
  typedef logic [23:0] sltc_lanes_t;
  // Test mode indications from the mode selector
  typedef struct packed {
    logic test_mode;   // Any serial-lane test mode active
    logic needs_sync;  // Current test mode needs synchronisation
  } sltc_mode_s;
  // Per-lane outputs toward generators and checkers
  typedef struct packed {
    sltc_lanes_t participate; // Lane generates and checks
    sltc_lanes_t rx_ignore;   // Lane input ignored
    sltc_lanes_t tx_quiet;    // Lane transmit held quiescent
    sltc_lanes_t tx_invert;   // Lane transmit inverted
    logic        tx_resync;   // Pulse: generators resync
    logic        rx_resync;   // Pulse: checkers resync
  } sltc_lane_ctl_s;
endpackage : sltc_pkg

//--- hdl/sltc_regs.svh
// Notes on behaviour
// - Eight lane enables per port, successive bytes.
// - Enabled lanes generate and check in test.
// - Disabled lanes ignore input, transmit held quiet.
// - Enables have no effect outside test mode.
// - All lane enables reset to ones.
// - Invert selected lane's transmit stream, any mode.
// - Write one starts every generator's resync when mode needs sync.
// - Write one starts every checker's resync when mode needs sync.
// - Resync bits are triggers, read zero.
// - Failure set: test mode, lane enabled, error.
// - Failures reset zero, sticky, write-one clears.
`ifndef SLTC_REGS_SVH
`define SLTC_REGS_SVH
`define SLTC_CTRL_OFS     12'h0bc
`define SLTC_FAIL_OFS     12'h0c0
`define SLTC_IMASK_OFS    12'h0d0
`define SLTC_SEL_OFS      12'h0d4
`define SLTC_MODE_OFS     12'h0d8
`define SLTC_INV_BIT      24
`define SLTC_TX_RESYNC_TRIGGER_BIT     25
`define SLTC_RX_RESYNC_TRIGGER_BIT     26
`define SLTC_EN_RST       24'hffffff
`define SLTC_FAIL_RST     24'h000000
`define SLTC_INV_RST      1'b0
`define SLTC_MASK_RST     24'h000000
`define SLTC_LSEL_RST     3'h0
`define SLTC_PSEL_RST     2'h0
`define SLTC_ADDR_W       12
`endif

//--- hdl/sltc_top.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sltc_regs.svh"
module sltc_top (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [11:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Mode and lane errors
  input  wire sltc_pkg::sltc_mode_s    mode_i,
  input  wire sltc_pkg::sltc_lanes_t   lane_err_i,
  // Lane control and interrupt
  output sltc_pkg::sltc_lane_ctl_s     lane_ctl_o,
  output logic                         irq_o
);
  // Register state
  sltc_pkg::sltc_lanes_t lane_en, next_lane_en;     // Lane enables
  logic                  invert, next_invert;       // Invert control
  sltc_pkg::sltc_lanes_t fail, next_fail;           // Sticky failures
  sltc_pkg::sltc_lanes_t imask, next_imask;         // Interrupt mask
  logic [2:0]            lsel, next_lsel;           // Count lane select zero
  logic [1:0]            psel, next_psel;           // Count port select zero
  logic [31:0]           rdata, next_rdata;         // Read data
  logic                  ack, next_ack;             // Bus acknowledge
  sltc_pkg::sltc_lane_ctl_s ctl, next_ctl;          // Lane control flops
  logic                  irq, next_irq;             // Interrupt flop

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bus request handshake helpers
  logic req;      // New request this cycle
  logic wr;       // Write strobe on the accept edge
  logic [31:0] wmask; // Byte enable mask
  assign req   = wb_cyc_i && wb_stb_i && !ack;
  assign wr    = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Write decode: a taken write aimed at one register offset
  function automatic logic wr_hit(input logic        w,
                                  input logic [11:0] adr,
                                  input logic [11:0] ofs);
    return w && (adr == ofs);
  endfunction : wr_hit

  // One-hot lane vector for a port and lane select
  function automatic sltc_pkg::sltc_lanes_t lane_onehot(input logic [1:0] p,
                                                         input logic [2:0] l);
    sltc_pkg::sltc_lanes_t v; // Result vector
    v = 24'h0;
    // Reserved port select points at no lane at all
    if (p != 2'h3) begin
      v[{p, l}] = 1'b1; // Bit 8*port+lane
    end
    return v;
  endfunction : lane_onehot

  // Bus answer next-state: every taken request is answered one cycle later
  always_comb begin
    next_ack   = req;   // Single-cycle acknowledge, never stretched
    next_rdata = rdata; // Read data holds between requests
    // Read mux; resync and reserved bits read zero
    if (req) begin
      unique case (wb_adr_i)
        `SLTC_CTRL_OFS: begin
          next_rdata = {7'h0, invert, lane_en};
        end
        `SLTC_FAIL_OFS: begin
          next_rdata = {8'h0, fail};
        end
        `SLTC_IMASK_OFS: begin
          next_rdata = {8'h0, imask}; // Interrupt mask readback
        end
        `SLTC_SEL_OFS: begin
          next_rdata = {27'h0, psel, lsel}; // Lane and port select readback
        end
        `SLTC_MODE_OFS: begin
          next_rdata = {30'h0, mode_i.needs_sync, mode_i.test_mode}; // Mode readback
        end
        default: begin
          next_rdata = 32'h0; // Unmapped offsets read zero
        end
      endcase
    end
  end

  // Bus answer flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;  // Nothing pending after reset
      rdata <= 32'h0; // Read data cleared
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Control register next-state: enables and invert, merged per byte lane
  always_comb begin
    logic [31:0] m; // Merged control word
    m            = merge({7'h0, invert, lane_en}, wb_dat_i, wb_sel_i);
    next_lane_en = lane_en; // Hold unless written
    next_invert  = invert;  // Hold unless written
    // Resync and reserved bits of the merged word are simply dropped
    if (wr_hit(wr, wb_adr_i, `SLTC_CTRL_OFS)) begin
      next_lane_en = m[23:0];
      next_invert  = m[`SLTC_INV_BIT];
    end
  end

  // Control register flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_en <= `SLTC_EN_RST;
      invert  <= `SLTC_INV_RST; // Inversion off after reset
    end else begin
      lane_en <= next_lane_en;
      invert  <= next_invert;
    end
  end

  // Failure flags next-state: clear applied first, new errors after it
  always_comb begin
    sltc_pkg::sltc_lanes_t clr_now; // Write-one clear pattern
    sltc_pkg::sltc_lanes_t hit_now; // Errors that count this cycle
    clr_now = 24'h0;
    // Only written ones in enabled byte lanes clear; zeros leave flags alone
    if (wr_hit(wr, wb_adr_i, `SLTC_FAIL_OFS)) begin
      clr_now = wb_dat_i[23:0] & wmask[23:0];
    end
    // An error counts only in test mode and on an enabled lane
    hit_now   = lane_err_i & lane_en & {24{mode_i.test_mode}};
    // Set wins over a clear in the same cycle so no error is lost
    next_fail = (fail & ~clr_now) | hit_now;
  end

  // Failure flag flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail <= `SLTC_FAIL_RST;
    end else begin
      fail <= next_fail;
    end
  end

  // Interrupt mask next-state: a one lets that lane's flag raise the interrupt
  always_comb begin
    logic [31:0] m; // Merged mask word
    m          = merge({8'h0, imask}, wb_dat_i, wb_sel_i);
    next_imask = imask; // Hold unless written
    if (wr_hit(wr, wb_adr_i, `SLTC_IMASK_OFS)) begin
      next_imask = m[23:0]; // Upper byte is reserved and dropped
    end
  end

  // Interrupt mask flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask <= `SLTC_MASK_RST; // All lanes masked out after reset
    end else begin
      imask <= next_imask;
    end
  end

  // Lane and port select next-state: chooses the lane that invert acts on
  always_comb begin
    logic [31:0] m; // Merged select word
    m         = merge({27'h0, psel, lsel}, wb_dat_i, wb_sel_i);
    next_lsel = lsel; // Hold unless written
    next_psel = psel; // Hold unless written
    if (wr_hit(wr, wb_adr_i, `SLTC_SEL_OFS)) begin
      next_lsel = m[2:0]; // Lane within the port
      next_psel = m[4:3]; // Port, three means none
    end
  end

  // Lane and port select flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lsel <= `SLTC_LSEL_RST; // Lane zero
      psel <= `SLTC_PSEL_RST; // First port
    end else begin
      lsel <= next_lsel;
      psel <= next_psel;
    end
  end

  // Lane control next-state
  always_comb begin
    logic ctrl_wr; // Top byte of the control word written this cycle
    ctrl_wr = wr_hit(wr, wb_adr_i, `SLTC_CTRL_OFS) && wb_sel_i[3];
    // Enables matter only in test mode
    if (mode_i.test_mode) begin
      next_ctl.participate = lane_en;
      next_ctl.rx_ignore   = ~lane_en;
      next_ctl.tx_quiet    = ~lane_en;
    end else begin
      next_ctl.participate = 24'h0;
      next_ctl.rx_ignore   = 24'h0;
      next_ctl.tx_quiet    = 24'h0;
    end
    // Invert acts in every mode, on the selected lane only
    if (invert) begin
      next_ctl.tx_invert = lane_onehot(psel, lsel);
    end else begin
      next_ctl.tx_invert = 24'h0; // Inversion off
    end
    // Resync triggers are one-cycle pulses, never stored, so they read zero
    next_ctl.tx_resync = ctrl_wr && wb_dat_i[`SLTC_TX_RESYNC_TRIGGER_BIT] && mode_i.needs_sync;
    next_ctl.rx_resync = ctrl_wr && wb_dat_i[`SLTC_RX_RESYNC_TRIGGER_BIT] && mode_i.needs_sync;
  end

  // Lane control flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= '0; // All lanes idle, no pulses
    end else begin
      ctl <= next_ctl;
    end
  end

  // Interrupt next-state: level while any unmasked flag is set
  always_comb begin
    // Uses the next flag value so the interrupt rises with the flag
    next_irq = |(next_fail & imask);
  end

  // Interrupt flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq <= 1'b0; // Quiet after reset
    end else begin
      irq <= next_irq;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o   = rdata;
  assign wb_ack_o   = ack;
  assign lane_ctl_o = ctl;
  assign irq_o      = irq;
endmodule : sltc_top

//--- verification/sltc_lane_model.sv
`timescale 1ns/1ps
module sltc_lane_model (
  // Clock and error request
  input  wire logic            clk_i,
  input  wire logic [23:0]     hit_i,
  // Lane checker errors
  output sltc_pkg::sltc_lanes_t lane_err_o
);
  // Lane checkers flag an error one cycle after the bench asks
  always_ff @(posedge clk_i) lane_err_o <= hit_i;
endmodule : sltc_lane_model

//--- verification/sltc_properties.sv
`timescale 1ns/1ps
module sltc_properties (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [11:0]              wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire sltc_pkg::sltc_mode_s     mode_i,
  input wire sltc_pkg::sltc_lane_ctl_s lane_ctl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken this edge
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Top-byte write to the control register
  wire wc = tk && wb_we_i && wb_sel_i[3] && wb_adr_i == 12'h0bc;
  chk_ack_take: assert property (tk |=> wb_ack_o ##1 !wb_ack_o) else $error("ack");
  chk_read_zero: assert property (
    wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:25] == 7'h00) else $error("read bits");
  chk_quiet_off: assert property (
    !$past(mode_i.test_mode) |-> !lane_ctl_o.tx_quiet && !lane_ctl_o.rx_ignore)
    else $error("quiet off");
  chk_quiet_part: assert property (
    !$past(rst_i) && $past(mode_i.test_mode) |-> lane_ctl_o.tx_quiet == ~lane_ctl_o.participate
    && lane_ctl_o.rx_ignore == lane_ctl_o.tx_quiet) else $error("participation");
  chk_tx_resync: assert property (
    wc && mode_i.needs_sync && wb_dat_i[25] |=> lane_ctl_o.tx_resync) else $error("tx resync");
  chk_rx_resync: assert property (
    wc && mode_i.needs_sync && wb_dat_i[26] |=> lane_ctl_o.rx_resync) else $error("rx resync");
  chk_resync_cause: assert property (
    lane_ctl_o.tx_resync || lane_ctl_o.rx_resync |-> wb_ack_o) else $error("stray resync");
  chk_invert_one: assert property ($onehot0(lane_ctl_o.tx_invert)) else $error("invert");
endmodule : sltc_properties
bind sltc_top sltc_properties chk (.*);

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o;
  logic [11:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [23:0] hit = '0;
  sltc_pkg::sltc_mode_s mode_i = '0;
  sltc_pkg::sltc_lanes_t lane_err_i;
  sltc_pkg::sltc_lane_ctl_s lane_ctl_o;
  int err_total = 0, checks_done = 0;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
  sltc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_i, .lane_err_i, .lane_ctl_o, .irq_o);
  sltc_lane_model far (.clk_i, .hit_i(hit), .lane_err_o(lane_err_i));
  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // One classic cycle, waits for ack under a bound
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 9);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 9) begin err_total++; report_and_stop(); end
  endtask : wb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    `CHK(q, e)
  endtask : rd
  // Lane errors held for one cycle
  task automatic err(input logic [23:0] b);
    @(posedge clk_i) hit <= b;
    @(posedge clk_i) hit <= '0;
  endtask : err
  task automatic t_reset;
    rd(12'h0bc, 32'h00ffffff);
    rd(12'h0c0, 32'h0);
    wb(1'b1, 12'h0fc, 32'hffffffff);
    rd(12'h0fc, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fail;
    wb(1'b1, 12'h0d0, 32'h00000200);
    wb(1'b1, 12'h0bc, 32'hf8fffffe);
    rd(12'h0bc, 32'h00fffffe);
    err(24'h010200);
    rd(12'h0c0, 32'h0);
    mode_i <= 2'b10;
    err(24'h010201);
    `CHK(lane_ctl_o.tx_quiet, 24'h000001)
    rd(12'h0c0, 32'h00010200);
    `CHK(irq_o, 1'b1)
    wb(1'b1, 12'h0c0, 32'h0);
    rd(12'h0c0, 32'h00010200);
    wb(1'b1, 12'h0c0, 32'h00000200);
    rd(12'h0c0, 32'h00010000);
    `CHK(irq_o, 1'b0)
    fork
      err(24'h000200);
      begin
        @(posedge clk_i);
        wb(1'b1, 12'h0c0, 32'h00000200);
      end
    join
    rd(12'h0c0, 32'h00010200);
    `CHK(irq_o, 1'b1)
    $display("failure test done");
  endtask : t_fail
  task automatic t_inv;
    mode_i <= 2'b11;
    wb(1'b1, 12'h0d4, 32'h0000000a);
    wb(1'b1, 12'h0bc, 32'h07ffffff);
    rd(12'h0bc, 32'h01ffffff);
    `CHK(lane_ctl_o.tx_invert, 24'h000400)
    mode_i <= 2'b00;
    rd(12'h0d8, 32'h0);
    `CHK(lane_ctl_o.tx_invert, 24'h000400)
    $display("invert test done");
  endtask : t_inv
  initial forever #5 clk_i = ~clk_i;
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fail();
    t_inv();
    report_and_stop();
  end
endmodule : tb
